// ### core/icapt_pkg.sv
/*
  Shared constants for the input capture channel: register indices, field
  positions, reset values and mode encodings.
  Assumes a 16-bit register port addressed by word index.
*/
package icapt_pkg;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] ADDR_FIFO     = 3'h2;
  localparam logic [2:0] ADDR_STATUS   = 3'h3;
  localparam logic [2:0] ADDR_MASK     = 3'h4;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int C1_STOP_IDLE = 13;
  localparam int C1_TSEL_LO   = 10;
  localparam int C1_RATE_LO   = 5;
  localparam int C1_OVF       = 4;
  localparam int C1_BNE       = 3;
  localparam int C1_MODE_LO   = 0;
  localparam int C2_CASCADE   = 8;
  localparam int C2_TRIG_SEL  = 7;
  localparam int C2_TRIG_RUN  = 6;
  localparam int C2_SRC_LO    = 0;
  localparam int ST_CAPTURE   = 0;
  localparam int ST_OVERFLOW  = 1;

  // ----------------------------------------------------------------------
  // Reset values and counter limit
  // ----------------------------------------------------------------------
  localparam logic [4:0]  SRC_RESET   = 5'h0d;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_BOTH    = 3'h1;
  localparam logic [2:0] MODE_FALL    = 3'h2;
  localparam logic [2:0] MODE_RISE    = 3'h3;
  localparam logic [2:0] MODE_RISE4   = 3'h4;
  localparam logic [2:0] MODE_RISE16  = 3'h5;
  localparam logic [2:0] MODE_UNUSED  = 3'h6;
  localparam logic [2:0] MODE_IRQONLY = 3'h7;
  localparam logic [2:0] TB_TIMER3    = 3'h0;
  localparam logic [2:0] TB_TIMER2    = 3'h1;
  localparam logic [2:0] TB_TIMER4    = 3'h2;
  localparam logic [2:0] TB_TIMER5    = 3'h3;
  localparam logic [2:0] TB_TIMER1    = 3'h4;
  localparam logic [2:0] TB_SYSCLK    = 3'h7;
  localparam logic [4:0] SRC_NONE     = 5'h00;
  localparam logic [3:0] PRESCALE4    = 4'h3;
  localparam logic [3:0] PRESCALE16   = 4'hf;

endpackage

// ### core/icapt_edge.sv
/*
  Capture pin synchroniser and edge qualifier with rising-edge prescaler.
  Assumes the pin is asynchronous to ref_clk.
*/
`timescale 1ns/1ps
module icapt_edge (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       pin_async,
  input  wire logic [2:0] mode,
  input  wire logic       run,
  output logic            capture
);

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       prev;
    logic [3:0] pre;
  } icapt_edge_t;

  icapt_edge_t q;
  icapt_edge_t next_q;
  logic        rise;
  logic        fall;

  // Pin passes two flops; only s2 and prev feed the edge logic.
  always_comb begin
    next_q      = q;
    next_q.s1   = pin_async;
    next_q.s2   = q.s1;
    next_q.prev = q.s2;
    rise        = q.s2 & ~q.prev;
    fall        = ~q.s2 & q.prev;
    capture     = 1'b0;
    case (mode)
      icapt_pkg::MODE_BOTH:    capture = run & (rise | fall);
      icapt_pkg::MODE_FALL:    capture = run & fall;
      icapt_pkg::MODE_RISE,
      icapt_pkg::MODE_IRQONLY: capture = run & rise;
      icapt_pkg::MODE_RISE4: begin
        capture = run & rise & (q.pre[1:0] == icapt_pkg::PRESCALE4[1:0]);
      end
      icapt_pkg::MODE_RISE16: begin
        capture = run & rise & (q.pre == icapt_pkg::PRESCALE16);
      end
      default: capture = 1'b0;
    endcase
    // Prescaler restarts whenever a prescaled mode is not selected.
    if (mode != icapt_pkg::MODE_RISE4 && mode != icapt_pkg::MODE_RISE16) begin
      next_q.pre = 4'h0;
    end else if (run && rise) begin
      next_q.pre = q.pre + 4'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ### core/icapt_fifo.sv
/*
  Four-entry capture FIFO for 16-bit timestamps.
  Drops a push when full itself; the caller's logic does not gate push.
*/
`timescale 1ns/1ps
module icapt_fifo (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  input  wire logic        pop,
  output logic [15:0]      head,
  output logic             full,
  output logic             empty
);

  typedef struct packed {
    logic [3:0][15:0] mem;
    logic [1:0]       wp;
    logic [1:0]       rp;
    logic [2:0]       cnt;
  } icapt_fifo_t;

  icapt_fifo_t q;
  icapt_fifo_t next_q;
  logic        do_push;
  logic        do_pop;

  // A push into a full FIFO is discarded, keeping the oldest samples.
  always_comb begin
    next_q  = q;
    full    = (q.cnt == 3'h4);
    empty   = (q.cnt == 3'h0);
    head    = q.mem[q.rp];
    do_push = push & ~full;
    do_pop  = pop & ~empty;
    if (do_push) begin
      next_q.mem[q.wp] = push_data;
      next_q.wp        = q.wp + 2'h1;
    end
    if (do_pop) begin
      next_q.rp = q.rp + 2'h1;
    end
    next_q.cnt = q.cnt + {2'h0, do_push} - {2'h0, do_pop};
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule

// ### core/icapt_top.sv
/*
  Input capture channel with dedicated 16-bit counter, capture FIFO,
  interrupt rate divider, sync/trigger source handling and cascading.
  Assumes time base ticks, source events and partner signals come from
  logic on ref_clk; only the capture pin is asynchronous.

// Summary of operation
// - Idle-stop bit halts channel during idle.
// - Time-base field selects counter clock source.
// - Buffer-not-empty bit mirrors FIFO occupancy.
// - Cascade in both channels forms 32-bit unit.
// - Trigger select: trigger versus synchronise.
// - Trigger status set by hardware or software.
// - Source zero means free-running counter.
// - Source codes for compare channels, timers.
// - Source codes for other capture channels.
// - Source codes for comparators, converter, charge unit.
// - Counter wraps; captures push count into FIFO.
// - Sync resets counter; trigger waits for event.
// - Odd channel low half; wrap increments even.
// - Captures on rising, all, 4th, 16th edges.
*/
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module icapt_top (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        capture_input_pin,
  input  wire logic        cpu_idle,
  input  wire logic [4:0]  timer_ticks,
  input  wire logic [31:0] source_events,
  input  wire logic        channel_is_even,
  input  wire logic        partner_cascade_enable,
  input  wire logic        partner_wrap,
  input  wire logic        partner_capture,
  output logic             wrap_pulse,
  output logic             capture_pulse,
  output logic             capture_cascade_enable,
  output logic             irq
);

  typedef struct packed {
    logic        stop_idle;
    logic [2:0]  tsel;
    logic [1:0]  rate;
    logic [2:0]  mode;
    logic        cascade;
    logic        trig_sel;
    logic        trig_run;
    logic [4:0]  src;
    logic [15:0] count;
    logic [1:0]  nth;
    logic        ovf;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [15:0] rdata;
    logic        irq;
    logic        wrap;
    logic        cap_out;
  } icapt_state_t;

  icapt_state_t q;
  icapt_state_t next_q;

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------

  // Time base tick for the selected clock; reserved codes never tick.
  function automatic logic tb_tick(input logic [2:0] sel, input logic [4:0] t);
    case (sel)
      icapt_pkg::TB_SYSCLK: tb_tick = 1'b1;
      icapt_pkg::TB_TIMER1: tb_tick = t[0];
      icapt_pkg::TB_TIMER2: tb_tick = t[1];
      icapt_pkg::TB_TIMER3: tb_tick = t[2];
      icapt_pkg::TB_TIMER4: tb_tick = t[3];
      icapt_pkg::TB_TIMER5: tb_tick = t[4];
      default:              tb_tick = 1'b0;
    endcase
  endfunction

  // Reserved source codes (1000x, 11111) and code zero never fire.
  function automatic logic src_hit(input logic [4:0] s, input logic [31:0] ev);
    if (s == icapt_pkg::SRC_NONE || s[4:1] == 4'h8 || s == 5'h1f) begin
      src_hit = 1'b0;
    end else begin
      src_hit = ev[s];
    end
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  logic        halted;
  logic        own_capture;
  logic        fifo_push;
  logic        fifo_pop;
  logic [15:0] fifo_head;
  logic        fifo_full;
  logic        fifo_empty;

  icapt_edge u_edge (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .pin_async (capture_input_pin),
    .mode      (q.mode),
    .run       (~halted),
    .capture   (own_capture)
  );

  icapt_fifo u_fifo (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .push      (fifo_push),
    .push_data (q.count),
    .pop       (fifo_pop),
    .head      (fifo_head),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  // ----------------------------------------------------------------------
  // Channel datapath and register file
  // ----------------------------------------------------------------------
  logic        cascaded;
  logic        as_even;
  logic        hit;
  logic        tick;
  logic        sync_clear;
  logic        count_en;
  logic        cap_ev;
  logic        irq_ev;
  logic        ovf_ev;
  logic [1:0]  set_bits;
  logic [15:0] ctrl_one;
  logic [15:0] ctrl_two;

  always_comb begin
    next_q   = q;
    halted   = q.stop_idle & cpu_idle;
    cascaded = q.cascade & partner_cascade_enable;
    as_even  = cascaded & channel_is_even;
    hit      = src_hit(q.src, source_events);
    // Even half counts on the odd half's wraps instead of its time base.
    tick     = as_even ? partner_wrap : tb_tick(q.tsel, timer_ticks);
    // The even half always follows its partner in synchronous fashion.
    sync_clear = (~q.trig_sel | as_even) & (q.src != icapt_pkg::SRC_NONE) & hit;
    count_en = ~halted & tick & (~q.trig_sel | as_even | q.trig_run);
    // Even half captures when its odd partner does, so both halves match.
    cap_ev   = as_even ? partner_capture : own_capture;
    fifo_push = cap_ev & (q.mode != icapt_pkg::MODE_IRQONLY);
    ovf_ev   = fifo_push & fifo_full;
    fifo_pop = reg_rd & (reg_addr == icapt_pkg::ADDR_FIFO);
    irq_ev   = 1'b0;
    set_bits = 2'h0;

    // Counter: sync reset wins, else free-running wrap.
    if (sync_clear && !halted) begin
      next_q.count = 16'h0000;
    end else if (count_en) begin
      next_q.count = q.count + 16'h0001;
    end
    next_q.wrap = count_en & ~sync_clear & (q.count == icapt_pkg::COUNT_MAX);

    // Trigger status: a source event sets it and holds the counter running.
    if (q.trig_sel && hit) begin
      next_q.trig_run = 1'b1;
    end

    // Every Nth capture raises the capture interrupt.
    if (cap_ev) begin
      if (q.nth >= q.rate) begin
        next_q.nth = 2'h0;
        irq_ev     = 1'b1;
      end else begin
        next_q.nth = q.nth + 2'h1;
      end
    end
    if (q.mode == icapt_pkg::MODE_OFF || q.mode == icapt_pkg::MODE_UNUSED) begin
      next_q.nth = 2'h0;
    end

    // Overflow is sticky until the FIFO has been read empty.
    if (ovf_ev) begin
      next_q.ovf = 1'b1;
    end else if (fifo_empty) begin
      next_q.ovf = 1'b0;
    end

    set_bits[icapt_pkg::ST_CAPTURE]  = irq_ev;
    set_bits[icapt_pkg::ST_OVERFLOW] = ovf_ev;

    ctrl_one = 16'h0000;
    ctrl_one[icapt_pkg::C1_STOP_IDLE] = q.stop_idle;
    ctrl_one[icapt_pkg::C1_TSEL_LO +: 3] = q.tsel;
    ctrl_one[icapt_pkg::C1_RATE_LO +: 2] = q.rate;
    ctrl_one[icapt_pkg::C1_OVF] = q.ovf;
    ctrl_one[icapt_pkg::C1_BNE] = ~fifo_empty;
    ctrl_one[icapt_pkg::C1_MODE_LO +: 3] = q.mode;
    ctrl_two = 16'h0000;
    ctrl_two[icapt_pkg::C2_CASCADE] = q.cascade;
    ctrl_two[icapt_pkg::C2_TRIG_SEL] = q.trig_sel;
    ctrl_two[icapt_pkg::C2_TRIG_RUN] = q.trig_run;
    ctrl_two[icapt_pkg::C2_SRC_LO +: 5] = q.src;

    // Register writes; hardware sets take priority over software clears.
    next_q.status = q.status | set_bits;
    if (reg_wr) begin
      case (reg_addr)
        icapt_pkg::ADDR_CTRL_ONE: begin
          next_q.stop_idle = reg_wdata[icapt_pkg::C1_STOP_IDLE];
          next_q.tsel = reg_wdata[icapt_pkg::C1_TSEL_LO +: 3];
          next_q.rate = reg_wdata[icapt_pkg::C1_RATE_LO +: 2];
          next_q.mode = reg_wdata[icapt_pkg::C1_MODE_LO +: 3];
        end
        icapt_pkg::ADDR_CTRL_TWO: begin
          next_q.cascade  = reg_wdata[icapt_pkg::C2_CASCADE];
          next_q.trig_sel = reg_wdata[icapt_pkg::C2_TRIG_SEL];
          // Software may write it, but a same-cycle trigger keeps it set.
          next_q.trig_run = reg_wdata[icapt_pkg::C2_TRIG_RUN] | (q.trig_sel & hit);
          next_q.src = reg_wdata[icapt_pkg::C2_SRC_LO +: 5];
        end
        icapt_pkg::ADDR_STATUS: begin
          next_q.status = (q.status & ~reg_wdata[1:0]) | set_bits;
        end
        icapt_pkg::ADDR_MASK: begin
          next_q.mask = reg_wdata[1:0];
        end
        default: begin
          next_q.mask = q.mask;
        end
      endcase
    end

    // Read data stands for exactly one cycle after the strobe.
    next_q.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        icapt_pkg::ADDR_CTRL_ONE: next_q.rdata = ctrl_one;
        icapt_pkg::ADDR_CTRL_TWO: next_q.rdata = ctrl_two;
        icapt_pkg::ADDR_FIFO:     next_q.rdata = fifo_empty ? 16'h0000 : fifo_head;
        icapt_pkg::ADDR_STATUS:   next_q.rdata = {14'h0000, q.status};
        icapt_pkg::ADDR_MASK:     next_q.rdata = {14'h0000, q.mask};
        default:                  next_q.rdata = 16'h0000;
      endcase
    end

    next_q.irq     = |(next_q.status & next_q.mask);
    next_q.cap_out = cap_ev;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q     <= '0;
      q.src <= icapt_pkg::SRC_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign reg_rdata              = q.rdata;
  assign wrap_pulse             = q.wrap;
  assign capture_pulse          = q.cap_out;
  assign capture_cascade_enable = q.cascade;
  assign irq                    = q.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_bne;
    @(posedge ref_clk) disable iff (!rstn)
      reg_rd && reg_addr == icapt_pkg::ADDR_CTRL_ONE |=> reg_rdata[3] == !$past(fifo_empty);
  endproperty
  a_bne: assert property (p_bne)
    else $error("not-empty bit disagrees with fifo");

  property p_wrap;
    @(posedge ref_clk) disable iff (!rstn)
      count_en && !sync_clear && q.count == 16'hffff |=> q.count == 16'h0000 && wrap_pulse;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("counter did not wrap to zero");

  property p_ovf;
    @(posedge ref_clk) disable iff (!rstn)
      fifo_push && fifo_full |=> q.ovf && q.status[1];
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");

  property p_trig;
    @(posedge ref_clk) disable iff (!rstn)
      q.trig_sel && hit |=> q.trig_run;
  endproperty
  a_trig: assert property (p_trig)
    else $error("trigger status not set");

  property p_sync;
    @(posedge ref_clk) disable iff (!rstn)
      !q.trig_sel && !halted && q.src != 5'h00 && hit |=> q.count == 16'h0000;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync event did not clear counter");

  property p_idle;
    @(posedge ref_clk) disable iff (!rstn)
      q.stop_idle && cpu_idle |=> $stable(q.count);
  endproperty
  a_idle: assert property (p_idle)
    else $error("counter moved while stopped in idle");

  property p_rate;
    @(posedge ref_clk) disable iff (!rstn)
      cap_ev && q.rate == 2'h0 && q.mode != 3'h0 && q.mode != 3'h6 |=> q.status[0];
  endproperty
  a_rate: assert property (p_rate)
    else $error("capture interrupt missing at rate one");

  property p_hold;
    @(posedge ref_clk) disable iff (!rstn)
      q.trig_sel && !q.trig_run && !as_even ##1 q.trig_sel && !q.trig_run
        |-> $stable(q.count) || $past(sync_clear);
  endproperty
  a_hold: assert property (p_hold)
    else $error("counter ran before trigger");

  property p_irq;
    @(posedge ref_clk) disable iff (!rstn)
      irq == |(q.status & q.mask);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output disagrees with status");

endmodule

// ### bench/icapt_pin_model.sv
/*
  Model of the external pulse source that drives the capture pin.
  Assumes go is a one-cycle request on ref_clk and the pin idles low.
*/
`timescale 1ns/1ps
module icapt_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       go,
  input  wire logic [7:0] count,
  input  wire logic [7:0] half,
  output logic            capture_input_pin,
  output logic            busy
);
  // ----------------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------------
  logic [8:0] left;
  logic [7:0] tick;

  // A burst of count pulses, half cycles high and half low, ends low.
  // The pin never rests high, so a stray edge cannot leak into the next burst.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      capture_input_pin <= 1'b0;
      left              <= 9'h000;
      tick              <= 8'h00;
    end else if (go) begin
      left <= {count, 1'b0};
      tick <= half;
    end else if (left != 9'h000) begin
      if (tick == 8'h01) begin
        capture_input_pin <= ~capture_input_pin;
        left              <= left - 9'h001;
        tick              <= half;
      end else begin
        tick <= tick - 8'h01;
      end
    end
  end

  assign busy = (left != 9'h000);
endmodule

// ### bench/tb_top.sv
/*
  Self-checking bench for the input capture channel.
  Assumes one 125 MHz clock and the pulse model on the capture pin.
*/
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        capture_input_pin;
  logic        cpu_idle = 1'b0;
  logic [4:0]  timer_ticks = 5'h00;
  logic [31:0] source_events = 32'h0;
  logic        channel_is_even = 1'b0;
  logic        partner_cascade_enable = 1'b0;
  logic        partner_wrap = 1'b0;
  logic        partner_capture = 1'b0;
  logic        capture_pulse;
  logic        wrap_pulse;
  logic        capture_cascade_enable;
  logic        irq;
  logic        go = 1'b0;
  logic [7:0]  count = 8'h00;
  logic [7:0]  half = 8'h00;
  logic        busy;
  logic [15:0] d;
  logic [15:0] v;
  logic [2:0]  tsel [6] = '{3'h4, 3'h1, 3'h0, 3'h2, 3'h3, 3'h6};
  logic [4:0]  tick [6] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
  int          err_count = 0;
  int          check_count = 0;
  int          caps = 0;
  int          c0;
  int          seed = 14;
  int          i;
  int          h;

  icapt_top dut (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .capture_input_pin, .cpu_idle, .timer_ticks, .source_events,
    .channel_is_even, .partner_cascade_enable, .partner_wrap, .partner_capture,
    .wrap_pulse, .capture_pulse, .capture_cascade_enable, .irq
  );

  icapt_pin_model pin_src (
    .ref_clk, .rstn, .go, .count, .half, .capture_input_pin, .busy
  );

  // ----------------------------------------------------------------------
  // Clock, capture counter and helpers
  // ----------------------------------------------------------------------
  always #4 ref_clk = ~ref_clk;

  // Counts capture pulses so bursts can be judged by difference.
  always @(posedge ref_clk) begin
    if (capture_pulse === 1'b1) begin
      caps <= caps + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] w);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= w;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there.
  task automatic rd(input logic [2:0] a, output logic [15:0] r);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    r = reg_rdata;
  endtask

  task automatic wc1(input logic s, input logic [2:0] t, input logic [1:0] r,
                     input logic [2:0] m);
    wr(icapt_pkg::ADDR_CTRL_ONE, {2'h0, s, t, 3'h0, r, 2'h0, m});
  endtask

  task automatic wc2(input logic c, input logic g, input logic ts, input logic [4:0] s);
    wr(icapt_pkg::ADDR_CTRL_TWO, {7'h00, c, g, ts, 1'b0, s});
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic drain;
    repeat (4) rd(icapt_pkg::ADDR_FIFO, d);
  endtask

  // Bounded wait: gives up after 5000 cycles and carries on if the model never finishes.
  task automatic pulses(input int n, input int hh);
    int g;
    @(posedge ref_clk);
    count <= 8'(n);
    half  <= 8'(hh);
    go    <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    #1;
    g = 0;
    while (busy !== 1'b0 && g < 5000) begin
      @(posedge ref_clk);
      g++;
    end
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic ev(input int k);
    @(posedge ref_clk);
    source_events <= 32'h1 << k;
    @(posedge ref_clk);
    source_events <= 32'h0;
  endtask

  task automatic pcap;
    @(posedge ref_clk);
    partner_capture <= 1'b1;
    @(posedge ref_clk);
    partner_capture <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Two rising edges 2*hh apart; returns the difference of the two timestamps.
  task automatic cap2(input int hh, output logic [15:0] dl);
    logic [15:0] a;
    pulses(2, hh);
    rd(icapt_pkg::ADDR_CTRL_ONE, d);
    chk(d[icapt_pkg::C1_BNE], 1'b1, "not empty");
    rd(icapt_pkg::ADDR_FIFO, a);
    rd(icapt_pkg::ADDR_FIFO, dl);
    dl = dl - a;
    rd(icapt_pkg::ADDR_CTRL_ONE, d);
    chk(d[icapt_pkg::C1_BNE], 1'b0, "empty");
  endtask

  function automatic int exp_caps(input int m);
    case (m)
      1: return 32;
      2, 3, 7: return 16;
      4: return 4;
      5: return 1;
      default: return 0;
    endcase
  endfunction

  function automatic int rnd(input int lo, input int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction

  initial begin
    repeat (60000) @(posedge ref_clk);
    err_count++;
    complete_run;
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(icapt_pkg::ADDR_CTRL_TWO, d);
    chk(d, {11'h000, icapt_pkg::SRC_RESET}, "ctrl two reset");
    rd(3'h7, d);
    chk(d, 16'h0000, "unmapped read");
    // Free running on the system clock.
    wc2(1'b0, 1'b0, 1'b0, icapt_pkg::SRC_NONE);
    wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'h0, icapt_pkg::MODE_RISE);
    for (i = 0; i < 3; i++) begin
      h = rnd(6, 30);
      cap2(h, v);
      chk(v, 16'(2 * h), "free run delta");
    end
    // Every mode code; a full FIFO that takes exactly four is no overflow.
    for (i = 0; i < 8; i++) begin
      wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'h0, 3'(i));
      c0 = caps;
      pulses(16, 4);
      chk(caps - c0, exp_caps(i), "captures per mode");
      rd(icapt_pkg::ADDR_CTRL_ONE, d);
      chk(d[icapt_pkg::C1_OVF], (i >= 1 && i <= 3), "overflow");
      drain;
      rd(icapt_pkg::ADDR_CTRL_ONE, d);
      chk(d[icapt_pkg::C1_OVF], 1'b0, "overflow cleared");
    end
    // Interrupt rate; mode off resets the rate count between runs.
    wr(icapt_pkg::ADDR_MASK, 16'h0001);
    for (i = 0; i < 4; i++) begin
      wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'h0, icapt_pkg::MODE_OFF);
      wr(icapt_pkg::ADDR_STATUS, 16'h0003);
      wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'(i), icapt_pkg::MODE_RISE);
      if (i > 0) begin
        pulses(i, 4);
        chk(irq, 1'b0, "irq early");
      end
      pulses(1, 4);
      rd(icapt_pkg::ADDR_STATUS, d);
      chk(d[icapt_pkg::ST_CAPTURE], 1'b1, "nth capture status");
      chk(irq, 1'b1, "irq on nth");
      drain;
    end
    wr(icapt_pkg::ADDR_MASK, 16'h0000);
    settle;
    chk(irq, 1'b0, "masked irq");
    wr(icapt_pkg::ADDR_MASK, 16'h0001);
    wr(icapt_pkg::ADDR_STATUS, 16'h0001);
    settle;
    chk(irq, 1'b0, "cleared irq");
    // Idle stop, then idle with the stop bit clear.
    cpu_idle <= 1'b1;
    wc1(1'b1, icapt_pkg::TB_SYSCLK, 2'h0, icapt_pkg::MODE_RISE);
    c0 = caps;
    pulses(2, 6);
    chk(caps - c0, 0, "halted in idle");
    wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'h0, icapt_pkg::MODE_RISE);
    h = rnd(6, 30);
    cap2(h, v);
    chk(v, 16'(2 * h), "runs in idle");
    cpu_idle <= 1'b0;
    // Time bases; a reserved code leaves the counter still.
    for (i = 0; i < 6; i++) begin
      wc1(1'b0, tsel[i], 2'h0, icapt_pkg::MODE_RISE);
      timer_ticks <= tick[i];
      h = rnd(6, 30);
      cap2(h, v);
      chk(v, (i < 5) ? 16'(2 * h) : 16'h0000, "time base delta");
    end
    timer_ticks <= 5'h00;
    wc1(1'b0, icapt_pkg::TB_SYSCLK, 2'h0, icapt_pkg::MODE_RISE);
    // Every source code that can fire; analog sources only as triggers.
    for (i = 1; i < 31; i++) begin
      if (i == 16 || i == 17) continue;
      wc2(1'b0, (i >= 24 && i <= 28), 1'b0, 5'(i));
      repeat (40) @(posedge ref_clk);
      ev(i);
      if (i >= 24 && i <= 28) begin
        settle;
        rd(icapt_pkg::ADDR_CTRL_TWO, d);
        chk(d[icapt_pkg::C2_TRIG_RUN], 1'b1, "trigger status");
      end else begin
        pulses(1, 8);
        rd(icapt_pkg::ADDR_FIFO, v);
        chk(v >= 16'h0006 && v <= 16'h001a, 1'b1, "sync clears");
      end
    end
    // Trigger by source, then by software.
    wc2(1'b0, 1'b1, 1'b0, 5'h0d);
    h = rnd(6, 30);
    cap2(h, v);
    chk(v, 16'h0000, "waits for trigger");
    ev(13);
    cap2(h, v);
    chk(v, 16'(2 * h), "runs after trigger");
    wc2(1'b0, 1'b1, 1'b0, icapt_pkg::SRC_NONE);
    cap2(h, v);
    chk(v, 16'h0000, "software trigger idle");
    wc2(1'b0, 1'b1, 1'b1, icapt_pkg::SRC_NONE);
    cap2(h, v);
    chk(v, 16'(2 * h), "software trigger runs");
    // Even member of a cascade counts partner wraps.
    channel_is_even        <= 1'b1;
    partner_cascade_enable <= 1'b1;
    wc2(1'b1, 1'b0, 1'b0, icapt_pkg::SRC_NONE);
    settle;
    chk(capture_cascade_enable, 1'b1, "cascade out");
    chk(wrap_pulse, 1'b0, "no stray wrap");
    h = rnd(3, 8);
    pcap;
    repeat (h) begin
      @(posedge ref_clk);
      partner_wrap <= 1'b1;
      @(posedge ref_clk);
      partner_wrap <= 1'b0;
    end
    pcap;
    rd(icapt_pkg::ADDR_FIFO, d);
    rd(icapt_pkg::ADDR_FIFO, v);
    chk(v - d, 16'(h), "upper half delta");
    partner_cascade_enable <= 1'b0;
    pcap;
    rd(icapt_pkg::ADDR_CTRL_ONE, d);
    chk(d[icapt_pkg::C1_BNE], 1'b0, "no cascade alone");
    complete_run;
  end
endmodule
